// file: core/cfg_lock_pkg.sv
// Purpose : constants for the configuration valid flag and port lock registers
// Assumes : 8-bit index-addressed configuration space
// Notes   : offsets are configuration indices
package cfg_lock_pkg;
  localparam logic [7:0] VALID_CYCLE_FLAG_IDX     = 8'h00;
  localparam logic [7:0] PORT_POWER_MODE_LOCK_IDX = 8'h01;
  localparam logic [7:0] LAST_CONFIG_INDEX        = 8'h39;
  localparam logic [7:0] VALID_CYCLE_FLAG_RST     = 8'h20;
  localparam logic [7:0] PORT_POWER_MODE_LOCK_RST = 8'h9C;
  localparam logic [7:0] VALID_FIXED_BITS         = 8'h20;
  localparam logic [7:0] LOCK_FIXED_BITS          = 8'h10;
  localparam int         VALID_BIT_POS            = 7;
  localparam int         POWER_BIT_POS            = 2;
  localparam int         PRINTER_BIT_POS          = 3;
  localparam int         LOCK_BIT_POS             = 7;
  localparam logic [9:0] BASE_DECODE_LIMIT        = 10'h100;
  localparam int         SYNC_STAGES              = 3;
endpackage

// file: core/pin_sync.sv
// Purpose : three-stage synchroniser with agreement filter for a pin input
// Assumes : single clock, active-low async reset
// Notes   : output changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync
  import cfg_lock_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b1
)
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);
  logic [SYNC_STAGES-1:0] stage_q;
  logic [SYNC_STAGES-1:0] stage_d;
  logic                   level_q;
  logic                   level_d;

  always_comb
  begin
    stage_d = {stage_q[SYNC_STAGES-2:0], i_pin};
    level_d = level_q;
    if (stage_q[1] == stage_q[2])
    begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage_q <= {SYNC_STAGES{RESET_VALUE}};
      level_q <= RESET_VALUE;
    end
    else
    begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;
endmodule

// file: core/config_valid_and_port_lock_regs.sv
// Purpose : valid-cycle flag and parallel port power/mode/lock registers
// Assumes : register port strobes are single-cycle, read data one cycle later
// Notes   : i_arst_n is the supply power-on reset; host bus reset is a pin
`timescale 1ns/100ps

// Overview of operation
// [R1] index 0x00 reachable only in config state
// [R2] index 0x01 reachable only in config state
// [R3] flag register bits 0-6 read 0x20
// [R4] bit 7 is software flag, no effect
// [R5] bit 2 powers parallel port, default on
// [R6] bit 3 selects printer mode, default set
// [R7] lock register bits 0,1,5,6 zero, 4 one
// [R8] lock bit gates access to indices 0-0x39
// [R9] lock cleared stays until hard reset
// [R10] power-on loads 0x20 and 0x9C
// [R11] power bit off keeps address decoding
// [R12] decode stops only when base below 0x100
// [R13] powered-down device still range-checked
// [R14] host bus reset pin acts as hard reset
// [R15] writes to read-only bits are ignored
module config_valid_and_port_lock_regs
  import cfg_lock_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_host_bus_reset_n,
  input  wire logic       i_config_state,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [9:0] i_pp_base_addr,
  input  wire logic [1:0] i_port_misc_mode,
  output logic [7:0]      o_rdata,
  output logic            o_cfg_access_ok,
  output logic            o_pp_powered,
  output logic            o_pp_printer_mode,
  output logic [1:0]      o_pp_ext_mode,
  output logic            o_pp_decode_en,
  output logic            o_pp_range_check
);
  typedef enum logic [1:0]
  {
    ACC_OPEN   = 2'b01,
    ACC_LOCKED = 2'b10
  } acc_state_t;

  logic       rst_meta_q;
  logic       rst_n_q;
  logic       hbr_n;
  logic       hard_reset;
  logic       valid_q;
  logic       valid_d;
  logic       power_q;
  logic       power_d;
  logic       printer_q;
  logic       printer_d;
  acc_state_t acc_q;
  acc_state_t acc_d;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       ok_d;
  logic       ok_q;
  logic       decode_d;
  logic       decode_q;
  logic       rng_d;
  logic       rng_q;
  logic       powered_q;
  logic       printer_o_q;
  logic [1:0] ext_q;
  logic [1:0] ext_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx,
                               input logic cfg, input logic open);
    hit = cfg && open && (a == idx);
  endfunction

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  pin_sync #(
    .RESET_VALUE (1'b1)
  ) u_hbr_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_q),
    .i_pin   (i_host_bus_reset_n),
    .o_level (hbr_n)
  );

  assign hard_reset = !hbr_n; // see [R14]

  logic open_now;
  logic wr_flag;
  logic wr_lock;
  logic rd_ok;
  assign open_now = (acc_q == ACC_OPEN);
  assign wr_flag  = i_wr && hit(i_addr, VALID_CYCLE_FLAG_IDX, i_config_state,
                                open_now); // see [R1]
  assign wr_lock  = i_wr && hit(i_addr, PORT_POWER_MODE_LOCK_IDX, i_config_state,
                                open_now); // see [R2]
  assign rd_ok    = i_config_state && open_now && (i_addr <= LAST_CONFIG_INDEX); // see [R8]

  always_comb
  begin
    valid_d   = valid_q;
    power_d   = power_q;
    printer_d = printer_q;
    acc_d     = acc_q;
    if (wr_flag)
    begin
      valid_d = i_wdata[VALID_BIT_POS]; // see [R4]
    end
    if (wr_lock)
    begin
      power_d   = i_wdata[POWER_BIT_POS]; // see [R5]
      printer_d = i_wdata[PRINTER_BIT_POS]; // see [R6]
    end
    case (acc_q)
      ACC_OPEN:
      begin
        if (wr_lock && !i_wdata[LOCK_BIT_POS])
        begin
          acc_d = ACC_LOCKED;
        end
      end
      ACC_LOCKED:
      begin
        acc_d = ACC_LOCKED; // see [R9]
      end
      default:
      begin
        acc_d = ACC_OPEN;
      end
    endcase
    if (hard_reset)
    begin
      acc_d = ACC_OPEN; // see [R9]
    end
  end

  // state leaves reset on the synchronised copy, never on the raw pin
  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      valid_q   <= VALID_CYCLE_FLAG_RST[VALID_BIT_POS]; // see [R10]
      power_q   <= PORT_POWER_MODE_LOCK_RST[POWER_BIT_POS];
      printer_q <= PORT_POWER_MODE_LOCK_RST[PRINTER_BIT_POS];
      acc_q     <= ACC_OPEN;
    end
    else
    begin
      valid_q   <= valid_d;
      power_q   <= power_d;
      printer_q <= printer_d;
      acc_q     <= acc_d;
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    if (i_rd && rd_ok)
    begin
      if (i_addr == VALID_CYCLE_FLAG_IDX)
      begin
        rdata_d = VALID_FIXED_BITS | {valid_q, 7'h00}; // see [R3] [R15]
      end
      else if (i_addr == PORT_POWER_MODE_LOCK_IDX)
      begin
        rdata_d = LOCK_FIXED_BITS | {open_now, 3'h0, printer_q, power_q, 2'h0}; // see [R7]
      end
    end
    ok_d     = open_now;
    decode_d = (i_pp_base_addr >= BASE_DECODE_LIMIT); // see [R11] [R12]
    rng_d    = decode_d; // see [R13]
    ext_d    = printer_q ? 2'b00 : i_port_misc_mode; // see [R6]
  end

  // outputs share the synchronised reset so they leave it with the state
  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rdata_q     <= 8'h00;
      ok_q        <= 1'b1;
      decode_q    <= 1'b0;
      rng_q       <= 1'b0;
      powered_q   <= 1'b1;
      printer_o_q <= 1'b1;
      ext_q       <= 2'b00;
    end
    else
    begin
      rdata_q     <= rdata_d;
      ok_q        <= ok_d;
      decode_q    <= decode_d;
      rng_q       <= rng_d;
      powered_q   <= power_q;
      printer_o_q <= printer_q;
      ext_q       <= ext_d;
    end
  end

  assign o_rdata           = rdata_q;
  assign o_cfg_access_ok   = ok_q;
  assign o_pp_powered      = powered_q;
  assign o_pp_printer_mode = printer_o_q;
  assign o_pp_ext_mode     = ext_q;
  assign o_pp_decode_en    = decode_q;
  assign o_pp_range_check  = rng_q;

  // read answers stand one cycle after the strobe and read zero otherwise
  stays_locked_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R9]
    (acc_q == ACC_LOCKED) && !hard_reset |=> acc_q == ACC_LOCKED)
    else $error("lock reopened without hard reset");
  hard_unlock_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R14]
    hard_reset |=> acc_q == ACC_OPEN)
    else $error("hard reset did not reopen access");
  hard_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R14]
    hard_reset && !wr_lock |=> $stable(power_q) && $stable(printer_q))
    else $error("hard reset disturbed power or mode");
  lock_take_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R9]
    wr_lock && !i_wdata[LOCK_BIT_POS] && !hard_reset |=> acc_q == ACC_LOCKED)
    else $error("clearing the lock bit did not lock");
  state_onehot_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R9]
    $onehot(acc_q))
    else $error("access state not one-hot");
  locked_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R8]
    i_rd && (acc_q == ACC_LOCKED) |=> o_rdata == 8'h00)
    else $error("read returned data while locked");
  locked_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R8]
    i_wr && (acc_q == ACC_LOCKED)
    |=> $stable(valid_q) && $stable(power_q) && $stable(printer_q))
    else $error("write took effect while locked");
  access_out_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R8]
    rst_n_q |=> o_cfg_access_ok == $past(open_now))
    else $error("access output does not follow lock");
  idle_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R8]
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data shown without a read");
  nocfg_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R1]
    i_rd && !i_config_state |=> o_rdata == 8'h00)
    else $error("read outside config state returned data");
  reserved_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R15]
    i_rd && (i_addr > PORT_POWER_MODE_LOCK_IDX) |=> o_rdata == 8'h00)
    else $error("unused index returned data");
  flag_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R3]
    i_rd && rd_ok && i_addr == VALID_CYCLE_FLAG_IDX |=> o_rdata[6:0] == 7'h20)
    else $error("fixed flag bits wrong");
  flag_bit_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R4]
    i_rd && rd_ok && i_addr == VALID_CYCLE_FLAG_IDX |=> o_rdata[7] == $past(valid_q))
    else $error("flag bit read back wrong");
  flag_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R4]
    wr_flag |=> valid_q == $past(i_wdata[VALID_BIT_POS]))
    else $error("flag bit not stored");
  lock_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R7]
    i_rd && rd_ok && i_addr == PORT_POWER_MODE_LOCK_IDX
    |=> o_rdata[7] && o_rdata[4] && o_rdata[1:0] == 2'b00 && o_rdata[6:5] == 2'b00)
    else $error("fixed lock bits wrong");
  nocfg_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R1]
    i_wr && !i_config_state && !hard_reset |=> $stable(valid_q) && $stable(power_q))
    else $error("write outside config state took effect");
  power_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R5]
    wr_lock |=> ##1 o_pp_powered == $past(i_wdata[POWER_BIT_POS], 2))
    else $error("power output did not follow write");
  printer_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R6]
    wr_lock |=> printer_q == $past(i_wdata[PRINTER_BIT_POS]))
    else $error("printer mode bit not stored");
  printer_out_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R6]
    rst_n_q |=> o_pp_printer_mode == $past(printer_q))
    else $error("printer mode output does not follow bit");
  ext_mode_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R6]
    printer_q |=> o_pp_ext_mode == 2'b00)
    else $error("extended mode leaked in printer mode");
  ext_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R6]
    !printer_q |=> o_pp_ext_mode == $past(i_port_misc_mode))
    else $error("extended mode not taken from misc bits");
  decode_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R12]
    rst_n_q |=> o_pp_decode_en == ($past(i_pp_base_addr) >= BASE_DECODE_LIMIT))
    else $error("decode does not follow base address");
  decode_power_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R11]
    $changed(power_q) && $stable(i_pp_base_addr) |=> $stable(o_pp_decode_en))
    else $error("power bit changed address decoding");
  range_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n_q) // see [R13]
    rst_n_q |=> o_pp_range_check == ($past(i_pp_base_addr) >= BASE_DECODE_LIMIT))
    else $error("range check does not follow base address");
  lock_cov: cover property (@(posedge i_clk) wr_lock && !i_wdata[LOCK_BIT_POS]);
  unlock_cov: cover property (@(posedge i_clk) (acc_q == ACC_LOCKED) ##1 hard_reset);
  flag_cov: cover property (@(posedge i_clk) wr_flag ##1 i_rd && rd_ok);
  ext_cov: cover property (@(posedge i_clk) !printer_q && i_port_misc_mode != 2'b00);
  decode_cov: cover property (@(posedge i_clk) !power_q && o_pp_decode_en);
endmodule

// file: verification/config_valid_and_port_lock_regs_test.sv
// Purpose : self-checking bench for the valid flag and port lock registers
// Assumes : register port answers one cycle after a read strobe
// Notes   : power-on defaults first, then table rows, lock, host bus reset and power-on cases
`timescale 1ns/100ps
`define CHK(g, w) begin checks++; if ((g) !== (w)) begin miscompares++; \
  $display("BAD %0t got %h want %h", $time, g, w); end end
module config_valid_and_port_lock_regs_test
  import cfg_lock_pkg::*;
;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic pw; logic pr;} row_t;
  logic       i_clk = 1'b0;
  logic       i_arst_n = 1'b0;
  logic       i_host_bus_reset_n = 1'b1;
  logic       i_config_state = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [9:0] i_pp_base_addr = 10'h0FF;
  logic [1:0] i_port_misc_mode = 2'h3;
  logic [7:0] o_rdata;
  logic       o_cfg_access_ok;
  logic       o_pp_powered;
  logic       o_pp_printer_mode;
  logic [1:0] o_pp_ext_mode;
  logic       o_pp_decode_en;
  logic       o_pp_range_check;
  int         miscompares = 0;
  int         checks = 0;
  logic [7:0] rd_v;
  // read-only bits set in the data must read back at their fixed values
  row_t rows [5] = '{
    '{8'h00, 8'hFF, 8'hA0, 1'b1, 1'b1}, '{8'h00, 8'h00, 8'h20, 1'b1, 1'b1},
    '{8'h01, 8'h98, 8'h98, 1'b0, 1'b1}, '{8'h01, 8'h97, 8'h94, 1'b1, 1'b0},
    '{8'h01, 8'hEC, 8'h9C, 1'b1, 1'b1}};

  config_valid_and_port_lock_regs dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_host_bus_reset_n(i_host_bus_reset_n),
    .i_config_state(i_config_state), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_pp_base_addr(i_pp_base_addr),
    .i_port_misc_mode(i_port_misc_mode), .o_rdata(o_rdata),
    .o_cfg_access_ok(o_cfg_access_ok), .o_pp_powered(o_pp_powered),
    .o_pp_printer_mode(o_pp_printer_mode), .o_pp_ext_mode(o_pp_ext_mode),
    .o_pp_decode_en(o_pp_decode_en), .o_pp_range_check(o_pp_range_check));

  initial
  begin
    forever #20 i_clk = ~i_clk;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic por();
    i_arst_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 rd_v = o_rdata;
    @(posedge i_clk);
  endtask

  initial
  begin
    #(40 * 4000);
    miscompares++;
    conclude();
  end

  initial
  begin
    por();
    `CHK(o_cfg_access_ok, 1'b1)
    `CHK(o_pp_printer_mode, 1'b1)
    rd(VALID_CYCLE_FLAG_IDX);
    `CHK(rd_v, 8'h20)
    rd(PORT_POWER_MODE_LOCK_IDX);
    `CHK(rd_v, 8'h9C)
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a);
      `CHK(rd_v, rows[k].r)
      `CHK(o_pp_powered, rows[k].pw)
      `CHK(o_pp_printer_mode, rows[k].pr)
      `CHK(o_pp_ext_mode, rows[k].pr ? 2'h0 : 2'h3)
    end
    rd(8'h05);
    `CHK(rd_v, 8'h00)
    // writes outside configuration state, one of them would lock if taken
    i_config_state <= 1'b0;
    wr(VALID_CYCLE_FLAG_IDX, 8'h80);
    wr(PORT_POWER_MODE_LOCK_IDX, 8'h18);
    rd(VALID_CYCLE_FLAG_IDX);
    `CHK(rd_v, 8'h00)
    rd(PORT_POWER_MODE_LOCK_IDX);
    `CHK(rd_v, 8'h00)
    i_config_state <= 1'b1;
    rd(VALID_CYCLE_FLAG_IDX);
    `CHK(rd_v, 8'h20)
    rd(PORT_POWER_MODE_LOCK_IDX);
    `CHK(rd_v, 8'h9C)
    `CHK(o_cfg_access_ok, 1'b1)
    // power off must not stop decoding; only the base address does
    i_pp_base_addr <= 10'h100;
    repeat (3) @(posedge i_clk);
    `CHK(o_pp_decode_en, 1'b1)
    wr(PORT_POWER_MODE_LOCK_IDX, 8'h98);
    repeat (2) @(posedge i_clk);
    `CHK(o_pp_powered, 1'b0)
    `CHK(o_pp_decode_en, 1'b1)
    `CHK(o_pp_range_check, 1'b1)
    i_pp_base_addr <= 10'h0FF;
    repeat (3) @(posedge i_clk);
    `CHK(o_pp_decode_en, 1'b0)
    `CHK(o_pp_range_check, 1'b0)
    wr(PORT_POWER_MODE_LOCK_IDX, 8'h18);
    repeat (2) @(posedge i_clk);
    `CHK(o_cfg_access_ok, 1'b0)
    wr(VALID_CYCLE_FLAG_IDX, 8'h80);
    rd(VALID_CYCLE_FLAG_IDX);
    `CHK(rd_v, 8'h00)
    wr(PORT_POWER_MODE_LOCK_IDX, 8'h9C);
    repeat (2) @(posedge i_clk);
    `CHK(o_cfg_access_ok, 1'b0)
    `CHK(o_pp_powered, 1'b0)
    i_host_bus_reset_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_host_bus_reset_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    `CHK(o_cfg_access_ok, 1'b1)
    `CHK(o_pp_powered, 1'b0)
    rd(PORT_POWER_MODE_LOCK_IDX);
    `CHK(rd_v, 8'h98)
    rd(VALID_CYCLE_FLAG_IDX);
    `CHK(rd_v, 8'h20)
    wr(VALID_CYCLE_FLAG_IDX, 8'h80);
    rd(VALID_CYCLE_FLAG_IDX);
    `CHK(rd_v, 8'hA0)
    // lock with extended modes chosen, then power-on reset must clear all
    wr(PORT_POWER_MODE_LOCK_IDX, 8'h10);
    i_port_misc_mode <= 2'h1;
    repeat (3) @(posedge i_clk);
    `CHK(o_pp_printer_mode, 1'b0)
    `CHK(o_pp_ext_mode, 2'h1)
    `CHK(o_cfg_access_ok, 1'b0)
    por();
    `CHK(o_pp_powered, 1'b1)
    `CHK(o_pp_printer_mode, 1'b1)
    `CHK(o_pp_ext_mode, 2'h0)
    `CHK(o_cfg_access_ok, 1'b1)
    rd(VALID_CYCLE_FLAG_IDX);
    `CHK(rd_v, 8'h20)
    rd(PORT_POWER_MODE_LOCK_IDX);
    `CHK(rd_v, 8'h9C)
    conclude();
  end
endmodule
